/* File: hdl/stage_map_pkg.sv */
package stage_map_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int NUM_STAGES = 12;
    localparam int NUM_INPUTS = 13;
    localparam int LOW_INPUTS = 7;
    localparam int HIGH_INPUTS = 6;
    localparam int STAGE_W = 4;
    localparam int ROUTE_W = 2;
    // register map
    localparam logic [9:0] STAGE_BASE_ADDR = 10'h080;
    localparam int STAGE_STRIDE_LOG2 = 3;
    localparam logic [2:0] WORD_MAP_LOW = 3'h0;
    localparam logic [2:0] WORD_MAP_HIGH = 3'h1;
    // field layout
    localparam int LOW_USED_W = 14;
    localparam int MODE_LSB = 12;
    localparam int NEG_GATE_BIT = 14;
    localparam int POS_GATE_BIT = 15;
    localparam int OFFSET_W = 6;
    // routing codes
    localparam logic [1:0] ROUTE_OPEN = 2'h0;
    localparam logic [1:0] ROUTE_NEG = 2'h1;
    localparam logic [1:0] ROUTE_POS = 2'h2;
    localparam logic [1:0] ROUTE_BIAS = 2'h3;
    // measurement mode codes
    localparam logic [1:0] MODE_BAD = 2'h0;
    localparam logic [1:0] MODE_SE_POS = 2'h1;
    localparam logic [1:0] MODE_SE_NEG = 2'h2;
    localparam logic [1:0] MODE_DIFF = 2'h3;
    // values after reset
    localparam logic [15:0] RD_DATA_RST = 16'h0000;
    localparam logic [12:0] SWITCH_RST = 13'h0000;
    localparam logic [5:0] OFFSET_RST = 6'h00;
endpackage : stage_map_pkg

/* File: hdl/stage_map_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module stage_map_mem
    import stage_map_pkg::*;
#(
    parameter int STAGES = NUM_STAGES
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_en_i,
    input wire logic [STAGE_W-1:0] wr_stage_i,
    input wire logic wr_high_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [STAGE_W-1:0] rd_a_stage_i,
    input wire logic rd_a_high_i,
    output logic [DATA_W-1:0] rd_a_data_o,
    input wire logic [STAGE_W-1:0] rd_b_stage_i,
    output logic [DATA_W-1:0] rd_b_low_o,
    output logic [DATA_W-1:0] rd_b_high_o
);
    typedef struct packed {
        logic [STAGES-1:0][LOW_USED_W-1:0] low;
        logic [STAGES-1:0][DATA_W-1:0] high;
        logic [STAGES-1:0] low_ok;
        logic [STAGES-1:0] high_ok;
        logic [DATA_W-1:0] a_data;
        logic [DATA_W-1:0] b_low;
        logic [DATA_W-1:0] b_high;
    } mem_state_t;

    mem_state_t st_r;
    mem_state_t st_nxt;

    // unwritten words read as zero so the switch matrix never sees undefined codes
    function automatic logic [DATA_W-1:0] fetch(input mem_state_t s, input logic [STAGE_W-1:0] stg,
                                               input logic hi);
        logic [DATA_W-1:0] v;
        v = '0;
        if (int'(stg) < STAGES)
        begin
            if (hi && s.high_ok[stg])
                v = s.high[stg];
            else if (!hi && s.low_ok[stg])
                v = {2'h0, s.low[stg]}; // top two bits are not stored and read zero
        end
        return v;
    endfunction : fetch

    always_comb
    begin
        st_nxt = st_r;
        if (wr_en_i && int'(wr_stage_i) < STAGES)
        begin
            if (wr_high_i)
            begin
                st_nxt.high[wr_stage_i] = wr_data_i;
                st_nxt.high_ok[wr_stage_i] = 1'b1;
            end
            else
            begin
                st_nxt.low[wr_stage_i] = wr_data_i[LOW_USED_W-1:0];
                st_nxt.low_ok[wr_stage_i] = 1'b1;
            end
        end
        st_nxt.a_data = fetch(st_r, rd_a_stage_i, rd_a_high_i);
        st_nxt.b_low = fetch(st_r, rd_b_stage_i, 1'b0);
        st_nxt.b_high = fetch(st_r, rd_b_stage_i, 1'b1);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rd_a_data_o = st_r.a_data;
    assign rd_b_low_o = st_r.b_low;
    assign rd_b_high_o = st_r.b_high;
endmodule : stage_map_mem
`default_nettype wire

/* File: hdl/stage_input_connection_matrix.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - twelve stages, each with its own pair of sixteen-bit connection words
// - route code 00 leaves the input isolated from both converter inputs
// - route code 01 joins the input to the converter negative input
// - route code 10 joins the input to the converter positive input
// - route code 11 ties the input to bias; software uses it for unused inputs
// - second word holds routes for inputs seven to twelve, same encoding
// - mode 01 is single-ended with one input on the positive side
// - mode 10 is single-ended with one input on the negative side
// - mode 11 is a differential measurement between both converter inputs
// - bit 14 of the second word at 1 suppresses the negative offset
// - bit 15 of the second word at 1 suppresses the positive offset
// - stage zero words at 0x080 and 0x081, each next stage eight addresses higher
// - each gate acts only on its own six-bit offset setting
module stage_input_connection_matrix
    import stage_map_pkg::*;
#(
    parameter int STAGES = NUM_STAGES
)
(
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [stage_map_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic WR_I,
    input wire logic [stage_map_pkg::DATA_W-1:0] WDATA_I,
    input wire logic RD_I,
    output logic [stage_map_pkg::DATA_W-1:0] RDATA_O,
    output logic RVALID_O,
    input wire logic [stage_map_pkg::STAGE_W-1:0] STAGE_SEL_I,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] NEG_OFFSET_SETTING_I,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] POS_OFFSET_SETTING_I,
    output logic [stage_map_pkg::NUM_INPUTS-1:0] SW_NEG_O,
    output logic [stage_map_pkg::NUM_INPUTS-1:0] SW_POS_O,
    output logic [stage_map_pkg::NUM_INPUTS-1:0] SW_BIAS_O,
    output logic MODE_SE_POS_O,
    output logic MODE_SE_NEG_O,
    output logic MODE_DIFF_O,
    output logic [stage_map_pkg::OFFSET_W-1:0] NEG_OFFSET_O,
    output logic [stage_map_pkg::OFFSET_W-1:0] POS_OFFSET_O
);
    import stage_map_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic rd_pend;
        logic [NUM_INPUTS-1:0] sw_neg;
        logic [NUM_INPUTS-1:0] sw_pos;
        logic [NUM_INPUTS-1:0] sw_bias;
        logic se_pos;
        logic se_neg;
        logic diff;
        logic [OFFSET_W-1:0] neg_off;
        logic [OFFSET_W-1:0] pos_off;
    } top_state_t;

    typedef struct packed {
        logic hit;
        logic [STAGE_W-1:0] stage;
        logic high;
    } decode_t;

    // switch closures for one input; the matrix drives them straight from these bits
    typedef struct packed {
        logic neg;
        logic pos;
        logic bias;
    } route_t;

    // one-hot converter mode; all zero means no measurement is set up
    typedef struct packed {
        logic se_pos;
        logic se_neg;
        logic diff;
    } mode_t;

    top_state_t st_r;
    top_state_t st_nxt;
    decode_t wr_dec;
    decode_t rd_dec;
    logic [DATA_W-1:0] mem_a_data;
    logic [DATA_W-1:0] mem_b_low;
    logic [DATA_W-1:0] mem_b_high;
    logic [2*NUM_INPUTS-1:0] routes;
    logic wr_en;
    logic [STAGE_W-1:0] rd_stage;

    // shared by the write and read paths; other words of a stage block belong elsewhere
    function automatic decode_t decode(input logic [ADDR_W-1:0] addr);
        decode_t d;
        logic [ADDR_W-1:0] rel;
        d = '0;
        rel = addr - STAGE_BASE_ADDR;
        d.stage = rel[STAGE_STRIDE_LOG2 +: STAGE_W];
        d.high = (rel[STAGE_STRIDE_LOG2-1:0] == WORD_MAP_HIGH);
        d.hit = (addr >= STAGE_BASE_ADDR) && (int'(rel[ADDR_W-1:STAGE_STRIDE_LOG2]) < STAGES) &&
                ((rel[STAGE_STRIDE_LOG2-1:0] == WORD_MAP_LOW) ||
                 (rel[STAGE_STRIDE_LOG2-1:0] == WORD_MAP_HIGH));
        return d;
    endfunction : decode

    // at most one switch per input, so no code can join two nodes together
    function automatic route_t route_decode(input logic [ROUTE_W-1:0] code);
        route_t r;
        r = '0;
        unique case (code)
            ROUTE_OPEN:
                r = '0;
            ROUTE_NEG:
                r.neg = 1'b1;
            ROUTE_POS:
                r.pos = 1'b1;
            ROUTE_BIAS:
                r.bias = 1'b1;
        endcase
        return r;
    endfunction : route_decode

    // a stray 00 mode asserts no mode, leaving the front end idle rather than guessing
    function automatic mode_t mode_decode(input logic [ROUTE_W-1:0] field);
        mode_t m;
        m = '0;
        unique case (field)
            MODE_BAD:
                m = '0;
            MODE_SE_POS:
                m.se_pos = 1'b1;
            MODE_SE_NEG:
                m.se_neg = 1'b1;
            MODE_DIFF:
                m.diff = 1'b1;
        endcase
        return m;
    endfunction : mode_decode

    // each gate only ever touches its own setting; a suppressed offset reads as zero
    function automatic logic [OFFSET_W-1:0] gate_offset(input logic suppress, input logic [OFFSET_W-1:0] setting);
        return suppress ? OFFSET_RST : setting;
    endfunction : gate_offset

    assign wr_dec = decode(ADDR_I);
    assign rd_dec = decode(ADDR_I);
    // writes outside the two connection words of a live stage are dropped
    assign wr_en = WR_I && wr_dec.hit;
    // a miss points the read port past the last stage, where it answers zero
    assign rd_stage = rd_dec.hit ? rd_dec.stage : STAGE_W'(STAGES);

    stage_map_mem #(
        .STAGES(STAGES)
    ) u_mem (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .wr_en_i(wr_en),
        .wr_stage_i(wr_dec.stage),
        .wr_high_i(wr_dec.high),
        .wr_data_i(WDATA_I),
        .rd_a_stage_i(rd_stage),
        .rd_a_high_i(rd_dec.high),
        .rd_a_data_o(mem_a_data),
        .rd_b_stage_i(STAGE_SEL_I),
        .rd_b_low_o(mem_b_low),
        .rd_b_high_o(mem_b_high)
    );

    // inputs 0..6 from the low word, 7..12 from the high word
    assign routes = {mem_b_high[2*HIGH_INPUTS-1:0], mem_b_low[2*LOW_INPUTS-1:0]};

    always_comb
    begin
        logic [ROUTE_W-1:0] code;
        route_t sw;
        mode_t md;
        code = ROUTE_OPEN;
        sw = '0;
        md = mode_decode(mem_b_high[MODE_LSB +: ROUTE_W]);
        st_nxt = st_r;
        // read answers two edges after the strobe: one edge fetches the word, one presents it
        st_nxt.rd_pend = RD_I;
        st_nxt.rvalid = st_r.rd_pend;
        st_nxt.rdata = st_r.rd_pend ? mem_a_data : RD_DATA_RST;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            code = routes[2*i +: 2];
            sw = route_decode(code);
            // open leaves all three switches off, so the input floats clear of both sides
            st_nxt.sw_neg[i] = sw.neg;
            st_nxt.sw_pos[i] = sw.pos;
            st_nxt.sw_bias[i] = sw.bias;
        end
        st_nxt.se_pos = md.se_pos;
        st_nxt.se_neg = md.se_neg;
        st_nxt.diff = md.diff;
        st_nxt.neg_off = gate_offset(mem_b_high[NEG_GATE_BIT], NEG_OFFSET_SETTING_I);
        st_nxt.pos_off = gate_offset(mem_b_high[POS_GATE_BIT], POS_OFFSET_SETTING_I);
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign RDATA_O = st_r.rdata;
    assign RVALID_O = st_r.rvalid;
    assign SW_NEG_O = st_r.sw_neg;
    assign SW_POS_O = st_r.sw_pos;
    assign SW_BIAS_O = st_r.sw_bias;
    assign MODE_SE_POS_O = st_r.se_pos;
    assign MODE_SE_NEG_O = st_r.se_neg;
    assign MODE_DIFF_O = st_r.diff;
    assign NEG_OFFSET_O = st_r.neg_off;
    assign POS_OFFSET_O = st_r.pos_off;
endmodule : stage_input_connection_matrix
`default_nettype wire

/* File: tb/stage_matrix_props.sv */
`timescale 1ns/1ns
`default_nettype none
module stage_matrix_props
    import stage_map_pkg::*;
#(
    parameter int STAGES = 12
)
(
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [stage_map_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic RD_I,
    input wire logic [stage_map_pkg::DATA_W-1:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic [stage_map_pkg::STAGE_W-1:0] STAGE_SEL_I,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] NEG_OFFSET_SETTING_I,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] POS_OFFSET_SETTING_I,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] SW_NEG_O,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] SW_POS_O,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] SW_BIAS_O,
    input wire logic MODE_SE_POS_O,
    input wire logic MODE_SE_NEG_O,
    input wire logic MODE_DIFF_O,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] NEG_OFFSET_O,
    input wire logic [stage_map_pkg::OFFSET_W-1:0] POS_OFFSET_O
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_B_I);
    a_read_answer: assert property (RD_I |-> ##2 RVALID_O)
        else $error("read answer missing");
    a_answer_cause: assert property (RVALID_O |-> $past(RD_I, 2))
        else $error("read answer without request");
    a_rdata_idle: assert property (!RVALID_O |-> RDATA_O == 16'h0000)
        else $error("read data not cleared");
    a_low_unused: assert property (RVALID_O && !$past(ADDR_I[0], 2) |-> RDATA_O[15:14] == 2'h0)
        else $error("unused low bits read nonzero");
    a_route_exclusive: assert property ((SW_NEG_O & SW_POS_O) == 0 &&
        (SW_BIAS_O & (SW_NEG_O | SW_POS_O)) == 0)
        else $error("input joined to two nodes");
    a_mode_onehot: assert property ($onehot0({MODE_SE_POS_O, MODE_SE_NEG_O, MODE_DIFF_O}))
        else $error("more than one mode");
    a_stage_off: assert property (STAGE_SEL_I >= STAGES |-> ##2
        (SW_NEG_O | SW_POS_O | SW_BIAS_O) == 0 && !MODE_DIFF_O && !MODE_SE_POS_O && !MODE_SE_NEG_O)
        else $error("stage out of range not idle");
    a_neg_offset: assert property (NEG_OFFSET_O != 6'h00 |-> NEG_OFFSET_O == $past(NEG_OFFSET_SETTING_I))
        else $error("negative offset not from its setting");
    a_pos_offset: assert property (POS_OFFSET_O != 6'h00 |-> POS_OFFSET_O == $past(POS_OFFSET_SETTING_I))
        else $error("positive offset not from its setting");
    c_read: cover property (RVALID_O);
    c_diff: cover property (MODE_DIFF_O && SW_POS_O != 0);
    c_gate: cover property (NEG_OFFSET_SETTING_I != 0 ##1 NEG_OFFSET_O == 0);
endmodule : stage_matrix_props
`default_nettype wire

/* File: tb/front_end_model.sv */
`timescale 1ns/1ns
`default_nettype none
module front_end_model
    import stage_map_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] sw_neg_i,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] sw_pos_i,
    input wire logic [stage_map_pkg::NUM_INPUTS-1:0] sw_bias_i,
    output logic short_o
);
    // sticky: a node shorted to bias or across the converter must never pass unseen
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            short_o <= 1'b0;
        else if (|((sw_neg_i & sw_pos_i) | (sw_bias_i & (sw_neg_i | sw_pos_i))))
            short_o <= 1'b1;
endmodule : front_end_model
`default_nettype wire

/* File: tb/stage_input_connection_matrix_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module stage_input_connection_matrix_tb_top;
    import stage_map_pkg::*;
    logic clk, rst_b, wr, rd, rvalid, mpos, mneg, mdiff, short;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STAGE_W-1:0] stage;
    logic [OFFSET_W-1:0] nset, pset, noff, poff;
    logic [NUM_INPUTS-1:0] swn, swp, swb;
    int bad_count = 0;
    int checked = 0;
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    stage_input_connection_matrix u_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_I(wr),
        .WDATA_I(wdata), .RD_I(rd), .RDATA_O(rdata), .RVALID_O(rvalid), .STAGE_SEL_I(stage),
        .NEG_OFFSET_SETTING_I(nset), .POS_OFFSET_SETTING_I(pset), .SW_NEG_O(swn), .SW_POS_O(swp),
        .SW_BIAS_O(swb), .MODE_SE_POS_O(mpos), .MODE_SE_NEG_O(mneg), .MODE_DIFF_O(mdiff),
        .NEG_OFFSET_O(noff), .POS_OFFSET_O(poff));
    front_end_model u_fe (.clk_i(clk), .rst_b_i(rst_b), .sw_neg_i(swn), .sw_pos_i(swp), .sw_bias_i(swb),
        .short_o(short));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic wr_word(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_word
    task automatic rd_word(input logic [9:0] a, input logic [15:0] exp);
        bit ok;
        ok = 0;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(negedge clk);
            ok = (rvalid === 1'b1);
        end
        if (!ok)
        begin
            bad_count++;
            $display("ERROR read answer expected 1 seen 0");
            summarize();
        end
        else
            chk("read data", rdata, exp);
    endtask : rd_word
    task automatic sel(input logic [3:0] s);
        @(posedge clk);
        stage <= s;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : sel
    initial
    begin
        rst_b = 1'b0;
        {wr, rd, addr, wdata, stage} = '0;
        nset = 6'h15;
        pset = 6'h2a;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_word(10'h080, 16'h0000);
        wr_word(10'h0d8, 16'hffff);
        wr_word(10'h0d9, 16'hffff);
        wr_word(10'h082, 16'h1234);
        rd_word(10'h0d8, 16'h3fff);
        rd_word(10'h0d9, 16'hffff);
        rd_word(10'h082, 16'h0000);
        rd_word(10'h0e0, 16'h0000);
        // in0 open, in1 neg, in2 pos, in7 neg, in8 pos, rest bias; differential, neg offset off
        wr_word(10'h080, 16'h3fe4);
        wr_word(10'h081, 16'h7ff9);
        sel(4'h0);
        chk("neg switches", 16'(swn), 16'h0082);
        chk("pos switches", 16'(swp), 16'h0104);
        chk("bias switches", 16'(swb), 16'h1e78);
        chk("offsets", {4'h0, noff, poff}, 16'h002a);
        chk("diff mode", 16'(mdiff), 16'h0001);
        sel(4'hb);
        chk("stage 11 bias", 16'(swb), 16'h1fff);
        sel(4'hc);
        chk("no stage", 16'(swn | swp | swb), 16'h0000);
        for (int m = 0; m < 4; m++)
        begin
            // single-ended modes get exactly one input on their side, differential gets one on each
            wr_word(10'h088, m == 3 ? 16'h0009 : (m == 1 ? 16'h0002 : 16'h0001));
            wr_word(10'h089, {m[1:0], m[1:0], 12'h000});
            sel(4'h1);
            chk("mode", 16'({mpos, mneg, mdiff}), 16'(m == 0 ? 3'b000 : 3'b100 >> (m - 1)));
            chk("se routes", 16'({swp[1:0], swn[1:0]}), m == 3 ? 16'h0009 : (m == 1 ? 16'h0004 : 16'h0001));
            chk("neg offset", 16'(noff), 16'(m[0] ? 6'h00 : 6'h15));
            chk("pos offset", 16'(poff), 16'(m[1] ? 6'h00 : 6'h2a));
            sel(4'hc);
        end
        chk("short", 16'(short), 16'h0000);
        summarize();
    end
endmodule : stage_input_connection_matrix_tb_top
bind stage_input_connection_matrix stage_matrix_props #(.STAGES(STAGES)) u_props (.CLOCK_I(CLOCK_I),
    .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
    .STAGE_SEL_I(STAGE_SEL_I), .NEG_OFFSET_SETTING_I(NEG_OFFSET_SETTING_I),
    .POS_OFFSET_SETTING_I(POS_OFFSET_SETTING_I), .SW_NEG_O(SW_NEG_O), .SW_POS_O(SW_POS_O),
    .SW_BIAS_O(SW_BIAS_O), .MODE_SE_POS_O(MODE_SE_POS_O), .MODE_SE_NEG_O(MODE_SE_NEG_O),
    .MODE_DIFF_O(MODE_DIFF_O), .NEG_OFFSET_O(NEG_OFFSET_O), .POS_OFFSET_O(POS_OFFSET_O));
`default_nettype wire
